// *** include/eepc_pkg.sv ***
// Purpose: Shared constants for the EEPROM program/erase controller
// Assumes: APB slave with 32-bit data, one 8-bit register per aligned word
// Notes: Array window maps one byte per word above the register page
package eepc_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W = 9;
    localparam int unsigned ARRAY_BYTES = 512;
    // Register byte offsets
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_NV_CONFIG = 12'h004;
    localparam logic [11:0] OFS_ARRAY_CONFIG = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam int unsigned ARRAY_SEL_BIT = 11;
    // Control register fields
    localparam int unsigned CTL_PUMP_CLOCK_SELECT = 7;
    localparam int unsigned CTL_ARRAY_POWER_DOWN = 5;
    localparam int unsigned CTL_ERASE_SELECT_HI = 4;
    localparam int unsigned CTL_ERASE_SELECT_LO = 3;
    localparam int unsigned CTL_LATCH_CONTROL = 2;
    localparam int unsigned CTL_PROGRAM_ERASE_ENABLE = 0;
    // Configuration register fields
    localparam int unsigned CFG_REDUNDANT_ARRAY_RESERVED = 7;
    localparam int unsigned CFG_CONFIG_BITS_HI = 6;
    localparam int unsigned CFG_CONFIG_BITS_LO = 5;
    localparam int unsigned CFG_SECURE_REGION_PROTECT = 4;
    localparam int unsigned CFG_BLOCK_PROTECT_HI = 3;
    // Status register fields
    localparam int unsigned STS_HV_ACTIVE = 0;
    localparam int unsigned STS_RECOVERING = 1;
    localparam int unsigned STS_OP_DONE = 2;
    // Reset and factory values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] NV_FACTORY = 8'h10;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // Secure region is the top 16 bytes of the array
    localparam logic [IDX_W-1:0] SECURE_BASE = 9'h1f0;
    // Timing counts in bus-clock cycles
    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] PROG_CYCLES_DEF = 16'h0190;
    localparam logic [15:0] BYTE_ERASE_CYCLES_DEF = 16'h0190;
    localparam logic [15:0] BLOCK_ERASE_CYCLES_DEF = 16'h0190;
    localparam logic [15:0] BULK_ERASE_CYCLES_DEF = 16'h0190;
    localparam logic [15:0] PD_RECOVERY_CYCLES_DEF = 16'h0028;
    localparam logic [15:0] STOP_RECOVERY_CYCLES_DEF = 16'h0028;
    // Program/erase modes from the two erase-select bits
    typedef enum logic [1:0] {
        EEPC_BYTE_PROGRAM = 2'h0,
        EEPC_BYTE_ERASE = 2'h1,
        EEPC_BLOCK_ERASE = 2'h2,
        EEPC_BULK_ERASE = 2'h3
    } eepc_mode_t;
endpackage

// *** src/eepc_ctrl.sv ***
// Purpose: EEPROM program/erase control with APB registers and array storage
// Assumes: Inputs synchronous to i_clk; i_por marks first power-up only
// Notes: Array occupies the upper half of the 4 KiB APB window, one byte per word
`timescale 1ns/1ps

module eepc_ctrl #(
    parameter logic [15:0] PROG_CYCLES = eepc_pkg::PROG_CYCLES_DEF,
    parameter logic [15:0] BYTE_ERASE_CYCLES = eepc_pkg::BYTE_ERASE_CYCLES_DEF,
    parameter logic [15:0] BLOCK_ERASE_CYCLES = eepc_pkg::BLOCK_ERASE_CYCLES_DEF,
    parameter logic [15:0] BULK_ERASE_CYCLES = eepc_pkg::BULK_ERASE_CYCLES_DEF,
    parameter logic [15:0] PD_RECOVERY_CYCLES = eepc_pkg::PD_RECOVERY_CYCLES_DEF,
    parameter logic [15:0] STOP_RECOVERY_CYCLES = eepc_pkg::STOP_RECOVERY_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_por,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [eepc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_stop,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_hv_on,
    output logic o_pump_clk_sel,
    output logic [7:0] o_array_config
);
    import eepc_pkg::*;

    logic [7:0] ctl_reg;
    logic [7:0] nv_reg;
    logic [7:0] acfg_reg;
    logic [7:0] mem [0:ARRAY_BYTES-1];
    logic lat_valid_reg;
    logic lat_nv_reg;
    logic [IDX_W-1:0] lat_idx_reg;
    logic [7:0] lat_data_reg;
    logic [CNT_W-1:0] op_cnt_reg;
    logic [CNT_W-1:0] rec_cnt_reg;
    logic done_reg;
    logic stop_prev_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic hv_reg;

    // APB decode; access completes on the edge where pready is seen high
    wire acc_phase = i_psel && i_penable;
    wire acc_done = acc_phase && pready_reg;
    wire is_array = i_paddr[ARRAY_SEL_BIT];
    wire [IDX_W-1:0] arr_idx = i_paddr[IDX_W+1:2];
    wire hit_ctl = !is_array && (i_paddr == OFS_CONTROL);
    wire hit_nv = !is_array && (i_paddr == OFS_NV_CONFIG);
    wire hit_acfg = !is_array && (i_paddr == OFS_ARRAY_CONFIG);
    wire hit_sts = !is_array && (i_paddr == OFS_STATUS);
    wire mapped = is_array || hit_ctl || hit_nv || hit_acfg || hit_sts;
    wire wr_done = acc_done && i_pwrite;
    wire rd_done = acc_done && !i_pwrite;
    wire [7:0] wdat = i_pwdata[7:0];

    // Control fields
    wire pump_clock_select = ctl_reg[CTL_PUMP_CLOCK_SELECT];
    wire array_power_down = ctl_reg[CTL_ARRAY_POWER_DOWN];
    wire latch_control = ctl_reg[CTL_LATCH_CONTROL];
    wire program_erase_enable = ctl_reg[CTL_PROGRAM_ERASE_ENABLE];
    wire [1:0] erase_sel = {ctl_reg[CTL_ERASE_SELECT_HI], ctl_reg[CTL_ERASE_SELECT_LO]};
    eepc_mode_t mode;
    assign mode = eepc_mode_t'(erase_sel);

    // Protection state; secure arming is taken from the nonvolatile bit or its array-configuration copy
    wire secure_on = !nv_reg[CFG_SECURE_REGION_PROTECT] || !acfg_reg[CFG_SECURE_REGION_PROTECT];
    wire [3:0] block_protect_bits = acfg_reg[CFG_BLOCK_PROTECT_HI:0];
    wire [1:0] lat_block = lat_idx_reg[IDX_W-1:IDX_W-2];
    wire lat_blk_prot = !lat_nv_reg && block_protect_bits[lat_block];
    wire lat_in_secure = !lat_nv_reg && (lat_idx_reg >= SECURE_BASE);
    wire arr_in_secure = arr_idx >= SECURE_BASE;

    // Whether the selected mode may run on the latched target
    wire byte_ok = !lat_blk_prot && !(secure_on && (lat_in_secure || lat_nv_reg));
    wire block_ok = !lat_blk_prot && !secure_on && !lat_nv_reg;
    wire bulk_ok = (block_protect_bits == 4'h0) && !secure_on && !lat_nv_reg;
    wire op_allowed = (mode == EEPC_BLOCK_ERASE) ? block_ok : (mode == EEPC_BULK_ERASE) ? bulk_ok : byte_ok;

    // High voltage: enable set, target allowed, not in stop; wait mode is not an input here
    wire hv_next = program_erase_enable && lat_valid_reg && op_allowed && !i_stop && !done_reg;
    wire [CNT_W-1:0] op_len = (mode == EEPC_BYTE_PROGRAM) ? PROG_CYCLES :
                              (mode == EEPC_BYTE_ERASE) ? BYTE_ERASE_CYCLES :
                              (mode == EEPC_BLOCK_ERASE) ? BLOCK_ERASE_CYCLES : BULK_ERASE_CYCLES;
    // Every cycle with high voltage applied counts, so a stop that cuts the voltage late costs no extra cycle
    wire commit = hv_reg && op_allowed && (op_cnt_reg == op_len - 16'h0001);

    // A write that may be latched as program/erase target
    wire valid_arr_wr = wr_done && is_array && !(secure_on && arr_in_secure);
    wire valid_nv_wr = wr_done && hit_nv && !secure_on;
    wire latch_wr = latch_control && !program_erase_enable && (valid_arr_wr || valid_nv_wr);

    // Control write: locked until a valid write is latched, then mode and enable interlocks
    wire ctl_wr = wr_done && hit_ctl;
    wire ctl_locked = latch_control && !lat_valid_reg;
    wire lat_keep = program_erase_enable && !wdat[CTL_LATCH_CONTROL];
    wire pge_set_ok = latch_control && lat_valid_reg;
    wire [1:0] sel_next = program_erase_enable ? erase_sel : wdat[CTL_ERASE_SELECT_HI:CTL_ERASE_SELECT_LO];
    wire [7:0] ctl_unlocked = {wdat[CTL_PUMP_CLOCK_SELECT], 1'b0, wdat[CTL_ARRAY_POWER_DOWN], sel_next,
                               wdat[CTL_LATCH_CONTROL] || lat_keep, 1'b0,
                               wdat[CTL_PROGRAM_ERASE_ENABLE] && (program_erase_enable || pge_set_ok)};
    wire [7:0] ctl_abort = {ctl_reg[7:3], wdat[CTL_LATCH_CONTROL], ctl_reg[1:0]};
    wire [7:0] ctl_next = !ctl_wr ? ctl_reg : ctl_locked ? ctl_abort : ctl_unlocked;

    // Recovery after power-down clear or stop exit
    wire pd_release = ctl_wr && array_power_down && !ctl_next[CTL_ARRAY_POWER_DOWN];
    wire stop_exit = stop_prev_reg && !i_stop;
    wire recovering = rec_cnt_reg != 16'h0000;

    // Read data selection; latched data shadows the array while latching
    wire [7:0] arr_rd = array_power_down ? READ_IDLE :
                        (latch_control && lat_valid_reg) ? lat_data_reg : mem[arr_idx];
    wire [7:0] sts_rd = {5'h00, done_reg, recovering, hv_reg};
    wire [7:0] rd_val = is_array ? arr_rd : hit_ctl ? ctl_reg : hit_nv ? nv_reg :
                        hit_acfg ? acfg_reg : hit_sts ? sts_rd : READ_IDLE;

    // Nonvolatile image of a committed operation on the configuration byte
    wire [7:0] nv_erased = {3'h7, nv_reg[CFG_SECURE_REGION_PROTECT], 4'hf};
    wire [7:0] nv_op = (mode == EEPC_BYTE_PROGRAM) ? (nv_reg & lat_data_reg) : nv_erased;

    // APB handshake: one wait state, answer and error from flops
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc_phase && !pready_reg;
            pslverr_reg <= acc_phase && !pready_reg && !mapped;
            if (acc_phase && !pready_reg) begin
                prdata_reg <= {24'h00_0000, rd_val};
            end
        end
    end

    // Control register; reset clears every bit
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctl_reg <= CONTROL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // Latched target address and data
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lat_valid_reg <= 1'b0;
            lat_nv_reg <= 1'b0;
            lat_idx_reg <= '0;
            lat_data_reg <= 8'h00;
        end else if (latch_wr) begin
            lat_valid_reg <= 1'b1;
            lat_nv_reg <= hit_nv;
            lat_idx_reg <= arr_idx;
            lat_data_reg <= wdat;
        end else if (!ctl_next[CTL_LATCH_CONTROL]) begin
            lat_valid_reg <= 1'b0;
        end
    end

    // Operation timer; stop freezes it so the operation resumes on exit
    always_ff @(posedge i_clk) begin
        if (i_srst || !program_erase_enable) begin
            op_cnt_reg <= '0;
            done_reg <= 1'b0;
            hv_reg <= 1'b0;
        end else begin
            hv_reg <= hv_next && !commit;
            if (commit) begin
                done_reg <= 1'b1;
            end
            if (hv_reg) begin
                op_cnt_reg <= op_cnt_reg + 16'h0001;
            end
        end
    end

    // Recovery counter and stop edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rec_cnt_reg <= '0;
            stop_prev_reg <= 1'b0;
        end else begin
            stop_prev_reg <= i_stop;
            if (stop_exit) begin
                rec_cnt_reg <= STOP_RECOVERY_CYCLES;
            end else if (pd_release) begin
                rec_cnt_reg <= PD_RECOVERY_CYCLES;
            end else if (recovering) begin
                rec_cnt_reg <= rec_cnt_reg - 16'h0001;
            end
        end
    end

    // Nonvolatile register: factory image at power-up, changed only by committed operations
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            nv_reg <= NV_FACTORY;
        end else if (commit && lat_nv_reg) begin
            nv_reg <= nv_op;
        end
    end

    // Array configuration: reloaded at reset and on each nonvolatile read
    always_ff @(posedge i_clk) begin
        if (i_srst || i_por) begin
            acfg_reg <= i_por ? NV_FACTORY : nv_reg;
        end else if (rd_done && hit_nv) begin
            acfg_reg <= nv_reg;
        end else if (wr_done && hit_acfg) begin
            acfg_reg <= {wdat[7:5], acfg_reg[CFG_SECURE_REGION_PROTECT], wdat[3:0]};
        end
    end

    // Array storage; each byte decides whether a committed operation hits it
    genvar gi;
    generate
        for (gi = 0; gi < ARRAY_BYTES; gi++) begin : g_byte
            localparam logic [IDX_W-1:0] IDX = IDX_W'(gi);
            wire hit_byte = !lat_nv_reg && (lat_idx_reg == IDX);
            wire hit_blk = !lat_nv_reg && (lat_block == IDX[IDX_W-1:IDX_W-2]);
            wire hit = (mode == EEPC_BULK_ERASE) ? !lat_nv_reg :
                       (mode == EEPC_BLOCK_ERASE) ? hit_blk : hit_byte;
            always_ff @(posedge i_clk) begin
                if (commit && hit) begin
                    mem[gi] <= (mode == EEPC_BYTE_PROGRAM) ? (mem[gi] & lat_data_reg) : ERASED_BYTE;
                end
            end
        end
    endgenerate

    // Outputs straight from flops
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_hv_on = hv_reg;
    assign o_pump_clk_sel = pump_clock_select;
    assign o_array_config = acfg_reg;
endmodule

// *** tb/eepc_cpu_model.sv ***
// Purpose: Processor-side APB master model for the EEPROM controller
// Assumes: One transfer at a time; signals change right after rising edges
// Notes: Released address and data are inverted so stale values never look valid
`timescale 1ns/1ps
module eepc_cpu_model (
    input wire logic i_clk,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [eepc_pkg::ADDR_W-1:0] o_paddr,
    output logic [31:0] o_pwdata
);
    import eepc_pkg::*;
    // Idle bus at time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0;
    end
    // One transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        // Waits as long as the slave needs; only the bench watchdog ends a hang
        do begin
            @(posedge i_clk);
        end while (i_pready !== 1'b1);
        q = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule

// *** tb/eepc_ctrl_checker.sv ***
// Purpose: Port-level assertions for the EEPROM controller
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Attached to every controller instance by bind
`timescale 1ns/1ps
module eepc_ctrl_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_por,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [eepc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_stop,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_hv_on,
    input wire logic o_pump_clk_sel,
    input wire logic [7:0] o_array_config
);
    import eepc_pkg::*;
    // Committed write to the control register
    wire ctl_wr = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == OFS_CONTROL);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    AST_ONE_WAIT: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("pready not after exactly one wait state");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
        else $error("pslverr outside an access");
    AST_RDATA_UPPER: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) i_srst |=> !o_pump_clk_sel && !o_hv_on)
        else $error("reset left pump select or high voltage set");
    AST_POR_LOAD: assert property (disable iff (1'b0) i_srst && i_por |=> o_array_config == NV_FACTORY)
        else $error("array config not loaded at reset");
    AST_PUMP_HOLD: assert property (!ctl_wr |=> $stable(o_pump_clk_sel))
        else $error("pump select changed without control write");
    AST_HV_OFF: assert property (ctl_wr && !i_pwdata[CTL_PROGRAM_ERASE_ENABLE] |-> ##[1:2] !o_hv_on)
        else $error("high voltage stayed on after enable cleared");
    AST_STOP_HV: assert property (i_stop ##1 i_stop |-> !o_hv_on)
        else $error("high voltage on during stop");
    AST_STOP_NO_RISE: assert property ($rose(o_hv_on) |-> !$past(i_stop))
        else $error("high voltage rose during stop");
    AST_SECURE_STICKY: assert property (!o_array_config[4] && !i_por |=> !o_array_config[4])
        else $error("secure protection disarmed");
endmodule
bind eepc_ctrl eepc_ctrl_checker u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_por(i_por), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_stop(i_stop),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_hv_on(o_hv_on),
    .o_pump_clk_sel(o_pump_clk_sel), .o_array_config(o_array_config));

// *** tb/eepc_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the EEPROM controller
// Assumes: Short operation and power-down recovery counts set at the instance
// Notes: Array reads happen only with the latch clear
`timescale 1ns/1ps
module eepc_ctrl_tb_top;
    import eepc_pkg::*;
    logic i_clk = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic stop = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, hv, pcs;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] acfg;
    int n_fail = 0;
    int n_checks = 0;
    // 40 MHz bus clock
    always #12.5 i_clk = ~i_clk;
    eepc_ctrl #(.PROG_CYCLES(16'h0008), .BYTE_ERASE_CYCLES(16'h0008), .BLOCK_ERASE_CYCLES(16'h0008),
        .BULK_ERASE_CYCLES(16'h0008), .PD_RECOVERY_CYCLES(16'h0004)) uut (
        .i_clk(i_clk), .i_srst(srst), .i_por(por), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_stop(stop), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_hv_on(hv), .o_pump_clk_sel(pcs), .o_array_config(acfg));
    eepc_cpu_model cpu (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
    task automatic close_out;
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        cpu.xfer(1'b1, a, d, q, e);
        chk(e, 1'b0);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        cpu.xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    // Latched program or erase; a negative count means the operation must be refused
    task automatic op(input logic [7:0] ctl, input logic [11:0] a, input logic [7:0] d, input int stop_at,
                      input int exp_hv);
        int hv_n;
        wr(OFS_CONTROL, {24'h0, ctl | 8'h04});
        wr(a, {24'h0, d});
        wr(OFS_CONTROL, {24'h0, ctl | 8'h05});
        hv_n = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge i_clk);
            if (hv === 1'b1)
                hv_n++;
            stop <= (i >= stop_at && i < stop_at + 6);
        end
        chk(hv_n, (exp_hv < 0) ? 0 : exp_hv);
        if (exp_hv > 0) begin
            wr(OFS_CONTROL, {24'h0, ctl | 8'h01});
            rdc(OFS_CONTROL, {24'h0, ctl | 8'h05});
        end
        wr(OFS_CONTROL, 32'h0);
        if (exp_hv > 0)
            rdc(OFS_CONTROL, {24'h0, ctl | 8'h04});
        wr(OFS_CONTROL, 32'h0);
        repeat (4) @(posedge i_clk);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        rdc(OFS_CONTROL, 32'h0);
        rdc(OFS_ARRAY_CONFIG, {24'h0, NV_FACTORY});
        chk(pcs, 1'b0);
        wr(OFS_CONTROL, 32'h80);
        rdc(OFS_CONTROL, 32'h80);
        chk(pcs, 1'b1);
        wr(OFS_CONTROL, 32'h0);
        cpu.xfer(1'b0, 12'h010, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
        wr(OFS_ARRAY_CONFIG, 32'h0f);
        rdc(OFS_ARRAY_CONFIG, 32'h1f);
        rdc(OFS_NV_CONFIG, {24'h0, NV_FACTORY});
        rdc(OFS_ARRAY_CONFIG, {24'h0, NV_FACTORY});
    endtask
    task automatic t_modes;
        op(8'h08, 12'h800, 8'h00, 99, 8);
        rdc(12'h800, 32'hff);
        op(8'h00, 12'h800, 8'h5a, 2, 8);
        rdc(12'h800, 32'h5a);
        op(8'h10, 12'h804, 8'h00, 99, 8);
        rdc(12'h800, 32'hff);
        op(8'h00, 12'h800, 8'h5a, 99, 8);
        op(8'h18, 12'hc00, 8'h00, 99, 8);
        rdc(12'h800, 32'hff);
        rdc(12'ha00, 32'hff);
    endtask
    task automatic t_protect;
        op(8'h00, 12'h800, 8'h5a, 99, 8);
        wr(OFS_ARRAY_CONFIG, 32'h01);
        @(posedge i_clk);
        chk(acfg, 8'h11);
        op(8'h08, 12'h800, 8'h00, 99, -1);
        rdc(12'h800, 32'h5a);
        op(8'h00, 12'ha00, 8'h33, 99, 8);
        rdc(12'ha00, 32'h33);
        op(8'h18, 12'ha00, 8'h00, 99, -1);
        rdc(12'ha00, 32'h33);
        wr(OFS_ARRAY_CONFIG, 32'h00);
        wr(OFS_CONTROL, 32'h20);
        rdc(12'h800, 32'h0);
        wr(OFS_CONTROL, 32'h0);
        repeat (4) @(posedge i_clk);
        rdc(12'h800, 32'h5a);
    endtask
    // Arm the one-time secure bit, prove it guards the top bytes, then reset mid-run
    task automatic t_secure;
        op(8'h00, OFS_NV_CONFIG, 8'hef, 99, 8);
        rdc(OFS_NV_CONFIG, 32'h00);
        op(8'h00, 12'hfc0, 8'h00, 99, -1);
        rdc(12'hfc0, 32'hff);
        op(8'h18, 12'h800, 8'h00, 99, -1);
        rdc(12'h800, 32'h5a);
        wr(OFS_ARRAY_CONFIG, 32'h1f);
        rdc(OFS_ARRAY_CONFIG, 32'h0f);
        @(posedge i_clk);
        srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        srst <= 1'b0;
        @(posedge i_clk);
        chk(acfg, 8'h00);
        rdc(OFS_CONTROL, 32'h0);
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (10) @(posedge i_clk);
        srst <= 1'b0;
        por <= 1'b0;
        t_regs();
        t_modes();
        t_protect();
        t_secure();
        close_out();
    end
    // Watchdog well beyond the expected run
    initial begin
        #(25 * 20000);
        n_fail++;
        close_out();
    end
endmodule
